// file: src/mdh_consts.svh
// constants for the modbus drive home and error monitor
// assumes a 50 MHz ref_clk and a byte-level modbus rtu framer outside
`ifndef MDH_CONSTS_SVH
`define MDH_CONSTS_SVH
`define MDH_CLK_HZ           50000000
`define MDH_REG_CMD          16'h007d
`define MDH_HOME_BIT         4
`define MDH_CMD_RST          16'h0000
`define MDH_FC_WRITE1        8'h06
`define MDH_FC_READ          8'h03
`define MDH_REG_ERRHIST      16'h0080
`define MDH_EX_ILL_FUNC      8'h01
`define MDH_EX_ILL_ADDR      8'h02
`define MDH_EX_ILL_VALUE     8'h03
`define MDH_EX_BUSY          8'h04
`define MDH_EC_TXERR         8'h84
`define MDH_EC_TIMEOUT       8'h85
`define MDH_EC_UNDEF         8'h88
`define MDH_EC_UIF           8'h89
`define MDH_EC_NVM           8'h8a
`define MDH_EC_RANGE         8'h8c
`define MDH_EC_EXDIS         8'h8d
`define MDH_BAUD_BAD_MIN     4'h8
`define MDH_CRC_INIT         16'hffff
`define MDH_CRC_POLY         16'ha001
`define MDH_SILENT_US        175
`define MDH_TB5_US           100
`define MDH_TB2_US           100
`define MDH_ACT_MS           4
`define MDH_CFG_MS           1000
`define MDH_TIMEOUT_MS       1000
`define MDH_ERR_ALARM_CNT    3
`define MDH_HIST_DEPTH       10
`endif

// file: src/mdh_pkg.sv
// types for the modbus drive home and error monitor
// constants live in mdh_consts.svh
package mdh_pkg;
   typedef struct packed {
      logic       valid;
      logic       sof;
      logic       eof;
      logic [7:0] data;
   } mdh_byte_t;
   typedef enum {ST_IDLE, ST_RX, ST_WAIT, ST_TX, ST_CFG} mdh_state_t;
   typedef struct packed {
      logic alarm;
      logic warning;
      logic baud_err;
      logic timeout;
   } mdh_status_t;
endpackage

// file: src/mdh_crc16.sv
// byte-serial crc-16 step for modbus rtu framing
// assumes one byte per call cycle, reflected polynomial
`timescale 1ns/10ps
`default_nettype none
`include "mdh_consts.svh"
module mdh_crc16 (
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  data,
   output logic      [15:0] crc_out
);
   logic [15:0] c;
   always_comb begin
      c = crc_in ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `MDH_CRC_POLY) : (c >> 1);
      end
      crc_out = c;
   end
endmodule
`default_nettype wire

// file: src/mdh_top.sv
// modbus rtu server: command register, error history, alarm/warning logic
// assumes a uart framer outside delivering bytes with sof/eof and taking tx bytes
`timescale 1ns/10ps
`default_nettype none
`include "mdh_consts.svh"
module mdh_top #(
   parameter int unsigned TIMEOUT_CYC = `MDH_TIMEOUT_MS * (`MDH_CLK_HZ / 1000),
   parameter int unsigned CFG_CYC     = `MDH_CFG_MS * (`MDH_CLK_HZ / 1000),
   parameter int unsigned ALARM_CNT   = `MDH_ERR_ALARM_CNT,
   parameter int unsigned HIST_DEPTH  = `MDH_HIST_DEPTH
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [7:0]       server_addr,
   input  wire logic [3:0]       baud_select_switch,
   input  wire mdh_pkg::mdh_byte_t rx_byte,
   input  wire logic             rx_error,
   input  wire logic             uif_active,
   input  wire logic             nvm_busy,
   input  wire logic             motor_busy,
   input  wire logic             stop_decel_mode,
   output mdh_pkg::mdh_byte_t    tx_byte,
   input  wire logic             tx_ready,
   output logic [15:0]           drive_input_command,
   output logic                  home_start,
   output logic                  motor_stop,
   output logic                  stop_immediate,
   output logic                  cfg_busy,
   output logic                  alarm_out,
   output logic                  warning_out,
   output logic                  alarm_led,
   output mdh_pkg::mdh_status_t  status,
   output logic [7:0]            last_error_code
);
   import mdh_pkg::*;
   localparam int unsigned CPU = `MDH_CLK_HZ / 1000000;
   localparam int unsigned SIL_CYC = `MDH_SILENT_US * CPU;
   localparam int unsigned RSP_CYC = (`MDH_SILENT_US + `MDH_TB5_US + `MDH_TB2_US) * CPU;
   localparam int unsigned ACT_CYC = SIL_CYC + `MDH_ACT_MS * (`MDH_CLK_HZ / 1000);
   localparam int unsigned BLINK_CYC = `MDH_CLK_HZ / 4;
   localparam int unsigned HW = $clog2(HIST_DEPTH);
   if (ALARM_CNT < 1 || ALARM_CNT > 255 || HIST_DEPTH < 2 || CFG_CYC < 1) begin
      $error("mdh_top: bad parameter");
   end

   typedef struct packed {
      mdh_state_t  st;
      logic [0:7][7:0] rx;
      logic [3:0]  n;
      logic [0:7][7:0] tx;
      logic [3:0]  tn;
      logic [3:0]  ti;
      logic [31:0] tmr;
      logic [31:0] idle;
      logic [31:0] blink;
      logic [7:0]  consec;
      logic [15:0] cmd;
      logic        home;
      logic        warn;
      logic        alarm;
      logic        tmo;
      logic        stop;
      logic [0:HIST_DEPTH-1][7:0] hist;
      logic [HW-1:0] hp;
      logic [7:0]  last;
      logic        led;
      mdh_byte_t   txb;
   } st_t;
   st_t s_r, s_nxt;

   logic [15:0] crc_q, crc_rx, crc_tx;
   logic [15:0] crc_acc_r, crc_acc_nxt;
   logic [15:0] tcrc_r, tcrc_nxt;
   logic [15:0] crc_seed;
   logic [HW-1:0] newest;
   logic [7:0]  tdata;
   logic        baud_bad;
   logic [7:0]  exc;
   logic [15:0] wval, waddr;

   // seed restarts on sof so the tail of an earlier frame never leaks in
   assign crc_seed = rx_byte.sof ? `MDH_CRC_INIT : crc_acc_r;
   mdh_crc16 u_crc_rx (.crc_in(crc_seed), .data(rx_byte.data), .crc_out(crc_rx));
   mdh_crc16 u_crc_tx (.crc_in(tcrc_r), .data(tdata), .crc_out(crc_tx));

   assign baud_bad = (baud_select_switch >= `MDH_BAUD_BAD_MIN);
   assign waddr = {s_r.rx[2], s_r.rx[3]};
   assign wval  = {s_r.rx[4], s_r.rx[5]};
   assign tdata = s_r.tx[s_r.ti[2:0]];
   assign crc_q = crc_acc_r;
   assign newest = (s_r.hp == '0) ? HW'(HIST_DEPTH - 1) : s_r.hp - HW'(1);

   // exception choice for a well-formed frame
   always_comb begin
      exc = 8'h00;
      if (s_r.rx[1] != `MDH_FC_WRITE1 && s_r.rx[1] != `MDH_FC_READ)
         exc = `MDH_EX_ILL_FUNC;
      else if (waddr != `MDH_REG_CMD && waddr != `MDH_REG_ERRHIST)
         exc = `MDH_EX_ILL_ADDR;
      else if (s_r.rx[1] == `MDH_FC_WRITE1 && waddr != `MDH_REG_CMD)
         exc = `MDH_EX_ILL_ADDR;
      // value check precedes busy, so a range error wins
      else if (s_r.rx[1] == `MDH_FC_WRITE1 && wval[15:8] != 8'h00)
         exc = `MDH_EX_ILL_VALUE;
      else if (s_r.rx[1] == `MDH_FC_WRITE1 && (uif_active || nvm_busy || motor_busy))
         exc = `MDH_EX_BUSY;
   end

   always_comb begin
      s_nxt = s_r;
      crc_acc_nxt = crc_acc_r;
      tcrc_nxt = tcrc_r;
      s_nxt.txb = '0;
      s_nxt.home = 1'b0;
      s_nxt.stop = 1'b0;
      // timeout alarm is sticky; only reset clears it
      if (s_r.idle < TIMEOUT_CYC) s_nxt.idle = s_r.idle + 32'd1;
      else if (!s_r.tmo) begin
         s_nxt.tmo = 1'b1;
         s_nxt.alarm = 1'b1;
         s_nxt.hist[s_r.hp] = `MDH_EC_TIMEOUT;
         s_nxt.hp = (s_r.hp == HW'(HIST_DEPTH-1)) ? '0 : s_r.hp + HW'(1);
         s_nxt.last = `MDH_EC_TIMEOUT;
      end
      // blink period far longer than any short test run
      if (s_r.alarm || baud_bad) begin
         s_nxt.blink = (s_r.blink >= BLINK_CYC - 1) ? 32'd0 : s_r.blink + 32'd1;
         if (s_r.blink >= BLINK_CYC - 1) s_nxt.led = ~s_r.led;
      end else begin
         s_nxt.led = 1'b0;
         s_nxt.blink = 32'd0;
      end
      // errors during our own reply are the line echo, not the client
      if (rx_error && s_r.st != ST_TX) begin
         s_nxt.hist[s_r.hp] = `MDH_EC_TXERR;
         s_nxt.hp = (s_r.hp == HW'(HIST_DEPTH-1)) ? '0 : s_r.hp + HW'(1);
         s_nxt.last = `MDH_EC_TXERR;
         s_nxt.warn = 1'b1;
         s_nxt.consec = (s_r.consec == 8'hff) ? s_r.consec : s_r.consec + 8'd1;
         if (32'(s_r.consec) + 32'd1 >= ALARM_CNT) s_nxt.alarm = 1'b1;
         s_nxt.st = ST_IDLE;
         s_nxt.n = '0;
      end else begin
         case (s_r.st)
            ST_IDLE, ST_RX: begin
               if (rx_byte.valid) begin
                  if (rx_byte.sof) begin
                     s_nxt.n = 4'd1;
                     s_nxt.rx[0] = rx_byte.data;
                     crc_acc_nxt = `MDH_CRC_INIT;
                  end else if (s_r.n < 4'd8) begin
                     s_nxt.rx[s_r.n[2:0]] = rx_byte.data;
                     s_nxt.n = s_r.n + 4'd1;
                  end
                  if (rx_byte.sof) crc_acc_nxt = crc_rx ^ 16'h0000;
                  s_nxt.st = ST_RX;
                  s_nxt.idle = 32'd0;
               end
               if (rx_byte.valid && !rx_byte.sof && s_r.n < 4'd6) crc_acc_nxt = crc_rx;
               if (s_r.st == ST_RX && rx_byte.valid && rx_byte.eof) begin
                  s_nxt.st = ST_IDLE;
                  // crc low then high must match bytes 0..5
                  if (s_r.n == 4'd7 && {rx_byte.data, s_r.rx[6]} == crc_q) begin
                     s_nxt.warn = 1'b0;
                     s_nxt.consec = 8'd0;
                     if (s_r.rx[0] == server_addr) begin
                        s_nxt.st = ST_WAIT;
                        s_nxt.tmr = 32'd0;
                     end
                  end
               end
            end
            ST_WAIT: begin
               // reply and operation both counted from the eof edge
               s_nxt.tmr = s_r.tmr + 32'd1;
               if (s_r.tmr == 32'(RSP_CYC - 1)) begin
                  s_nxt.tx[0] = s_r.rx[0];
                  s_nxt.ti = '0;
                  tcrc_nxt = `MDH_CRC_INIT;
                  s_nxt.st = ST_TX;
                  if (exc != 8'h00) begin
                     s_nxt.tx[1] = s_r.rx[1] | 8'h80;
                     s_nxt.tx[2] = exc;
                     s_nxt.tn = 4'd3;
                     s_nxt.last = (exc == `MDH_EX_ILL_VALUE) ? `MDH_EC_RANGE :
                                  (exc != `MDH_EX_BUSY) ? `MDH_EC_UNDEF :
                                  uif_active ? `MDH_EC_UIF :
                                  nvm_busy ? `MDH_EC_NVM : `MDH_EC_EXDIS;
                     s_nxt.hist[s_r.hp] = s_nxt.last;
                     s_nxt.hp = (s_r.hp == HW'(HIST_DEPTH-1)) ? '0 : s_r.hp + HW'(1);
                  end else if (s_r.rx[1] == `MDH_FC_READ) begin
                     s_nxt.tx[1] = `MDH_FC_READ;
                     s_nxt.tx[2] = 8'd2;
                     s_nxt.tx[3] = 8'h00;
                     s_nxt.tx[4] = (waddr == `MDH_REG_CMD) ? s_r.cmd[7:0] :
                                   s_r.hist[newest];
                     s_nxt.tn = 4'd5;
                  end else begin
                     for (int i = 1; i < 6; i++) s_nxt.tx[i] = s_r.rx[i];
                     s_nxt.tn = 4'd6;
                  end
               end
               // operation takes effect before the reply, well inside the act window
               if (s_r.tmr == 32'(SIL_CYC) && exc == 8'h00 && s_r.rx[1] == `MDH_FC_WRITE1) begin
                  s_nxt.cmd = wval;
                  if (wval[`MDH_HOME_BIT] && !s_r.cmd[`MDH_HOME_BIT] && !s_r.alarm)
                     s_nxt.home = 1'b1;
                  if (s_r.cmd != 16'h0000 && wval == 16'h0000) s_nxt.stop = 1'b1;
               end
            end
            ST_TX: begin
               // one byte per ready cycle, crc low byte first
               if (tx_ready) begin
                  s_nxt.txb.valid = 1'b1;
                  s_nxt.txb.sof = (s_r.ti == 4'd0);
                  if (s_r.ti < s_r.tn) begin
                     s_nxt.txb.data = tdata;
                     tcrc_nxt = crc_tx;
                  end else if (s_r.ti == s_r.tn) s_nxt.txb.data = tcrc_r[7:0];
                  else begin
                     s_nxt.txb.data = tcrc_r[15:8];
                     s_nxt.txb.eof = 1'b1;
                  end
                  s_nxt.ti = s_r.ti + 4'd1;
                  if (s_r.ti == s_r.tn + 4'd1) begin
                     s_nxt.st = (s_r.rx[1] == `MDH_FC_WRITE1 && exc == 8'h00) ?
                                ST_CFG : ST_IDLE;
                     s_nxt.tmr = 32'd0;
                  end
               end
            end
            ST_CFG: begin
               // queries during this window are not accepted
               s_nxt.tmr = s_r.tmr + 32'd1;
               if (s_r.tmr >= 32'(CFG_CYC - 1)) s_nxt.st = ST_IDLE;
            end
            default: s_nxt.st = ST_IDLE;
         endcase
      end
   end

   // asynchronous clear; history and warnings are lost with power
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.cmd <= `MDH_CMD_RST;
         crc_acc_r <= `MDH_CRC_INIT;
         tcrc_r <= `MDH_CRC_INIT;
      end else begin
         s_r <= s_nxt;
         crc_acc_r <= crc_acc_nxt;
         tcrc_r <= tcrc_nxt;
      end
   end

   assign tx_byte = s_r.txb;
   assign drive_input_command = s_r.cmd;
   assign home_start = s_r.home;
   // alarm stop is always immediate; decel choice only for commanded stops
   assign motor_stop = s_r.alarm | s_r.stop;
   assign stop_immediate = s_r.alarm | (s_r.stop & stop_decel_mode);
   assign cfg_busy = (s_r.st == ST_CFG);
   // high means healthy, so a dead line reads as alarm
   assign alarm_out = ~(s_r.alarm | baud_bad);
   assign warning_out = s_r.warn;
   assign alarm_led = s_r.led;
   assign status = '{alarm: s_r.alarm, warning: s_r.warn, baud_err: baud_bad, timeout: s_r.tmo};
   assign last_error_code = s_r.last;
endmodule
`default_nettype wire

// file: tb/mdh_client.sv
// modbus rtu client model: sends write queries, collects the reply bytes
// assumes one byte per ref_clk cycle on the receive path of mdh_top
`timescale 1ns/10ps
`default_nettype none
module mdh_client (
   input  wire logic               ref_clk,
   input  wire logic               slow,
   input  wire mdh_pkg::mdh_byte_t tx_byte,
   output mdh_pkg::mdh_byte_t      rx_byte,
   output logic                    tx_ready
);
   import mdh_pkg::*;
   logic [7:0] rsp [0:7];
   int         rsp_n = 0;
   initial rx_byte = '0;
   initial tx_ready = 1'b1;
   function automatic logic [15:0] crc16(input logic [47:0] f);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 5; i >= 0; i--) begin
         c = c ^ {8'h00, f[i*8 +: 8]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction
   // crc low byte first, then high; bad flips one bit
   task automatic send(input logic [47:0] f, input logic bad);
      logic [15:0] c;
      logic [63:0] fr;
      c = crc16(f) ^ {15'h0000, bad};
      fr = {f, c[7:0], c[15:8]};
      rsp_n = 0;
      for (int i = 7; i >= 0; i--) begin
         @(posedge ref_clk);
         #1;
         rx_byte = '{1'b1, i == 7, i == 0, fr[i*8 +: 8]};
      end
      @(posedge ref_clk);
      #1;
      // released line: inverse of last value, never a stale copy
      rx_byte = '{1'b0, 1'b0, 1'b0, ~rx_byte.data};
   endtask
   // slow mode stalls every other cycle
   always @(posedge ref_clk) begin
      #1;
      tx_ready = slow ? ~tx_ready : 1'b1;
   end
   always @(posedge ref_clk) begin
      if (tx_byte.valid === 1'b1 && rsp_n < 8) begin
         rsp[rsp_n] <= tx_byte.data;
         rsp_n <= rsp_n + 1;
      end
   end
endmodule
`default_nettype wire

// file: tb/mdh_chk.sv
// checker: reply timing, pulse and alarm relations at the mdh_top ports
// assumes ref_clk at 50 MHz; bound in at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module mdh_chk #(
   parameter int unsigned CFG_CYC = 200
) (
   input wire logic               ref_clk,
   input wire logic               rst_n,
   input wire logic [3:0]         baud_select_switch,
   input wire mdh_pkg::mdh_byte_t rx_byte,
   input wire logic               rx_error,
   input wire mdh_pkg::mdh_byte_t tx_byte,
   input wire logic [15:0]        drive_input_command,
   input wire logic               home_start,
   input wire logic               motor_stop,
   input wire logic               cfg_busy,
   input wire logic               alarm_out,
   input wire logic               warning_out,
   input wire mdh_pkg::mdh_status_t status,
   input wire logic [7:0]         last_error_code
);
   import mdh_pkg::*;
   localparam int RSP = 18750;
   localparam int ACT = 208750;
   logic [31:0] eof_cnt_r;
   logic [31:0] cfg_cnt_r;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // 32 bits never wrap within any realistic run
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         eof_cnt_r <= '0;
         cfg_cnt_r <= '0;
      end else begin
         eof_cnt_r <= (rx_byte.valid && rx_byte.eof) ? 32'd0 : eof_cnt_r + 32'd1;
         cfg_cnt_r <= cfg_busy ? cfg_cnt_r + 32'd1 : 32'd0;
      end
   end
   sequence err_seen;
      rx_error && alarm_out;
   endsequence
   sequence warn_or_alarm;
      ##[1:3] (warning_out || !alarm_out);
   endsequence
   home_level_a: assert property (home_start |-> ##[0:1] drive_input_command[4])
      else $error("home pulse without home bit");
   home_pulse_a: assert property (home_start |=> !home_start)
      else $error("home pulse longer than one cycle");
   reply_gap_a: assert property (tx_byte.valid |-> eof_cnt_r >= RSP - 1)
      else $error("reply began too early");
   act_time_a: assert property (home_start |-> eof_cnt_r <= ACT)
      else $error("operation start too late");
   cfg_len_a: assert property (cfg_cnt_r <= CFG_CYC + 2)
      else $error("configuration busy too long");
   alarm_stop_a: assert property (status.alarm |-> ##[0:1] (motor_stop && !alarm_out))
      else $error("alarm without stop and output off");
   alarm_hold_a: assert property (status.alarm |=> status.alarm)
      else $error("alarm dropped before reset");
   baud_bad_a: assert property (baud_select_switch[3] [*3] |-> !alarm_out)
      else $error("bad baud setting not flagged");
   warn_raise_a: assert property (err_seen |-> warn_or_alarm)
      else $error("transmission error raised no warning");
   err_code_a: assert property (err_seen |-> ##[1:3] last_error_code == 8'h84)
      else $error("transmission error code not recorded");
   timeout_alarm_a: assert property (status.timeout |-> status.alarm)
      else $error("timeout raised no alarm");
endmodule
bind mdh_top mdh_chk #(.CFG_CYC(CFG_CYC)) u_chk (.ref_clk, .rst_n, .baud_select_switch,
   .rx_byte, .rx_error, .tx_byte, .drive_input_command, .home_start, .motor_stop,
   .cfg_busy, .alarm_out, .warning_out, .status, .last_error_code);
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for mdh_top: writes, exceptions, error escalation
// assumes the client model owns the receive path and takes the replies
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import mdh_pkg::*;
   localparam int TMO = 25000;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  baud_select_switch = 4'h8;
   logic        rx_error = 1'b0;
   logic        slow = 1'b0;
   logic        uif_active = 1'b0;
   logic        nvm_busy = 1'b0;
   logic        motor_busy = 1'b0;
   logic        stop_decel_mode = 1'b0;
   mdh_byte_t   rx_byte;
   mdh_byte_t   tx_byte;
   logic        tx_ready, home_start, motor_stop, cfg_busy, alarm_out, warning_out;
   logic        stop_immediate, alarm_led;
   logic [15:0] drive_input_command;
   logic [7:0]  last_error_code;
   mdh_status_t status;
   int          err_count = 0;
   int          comparisons = 0;
   int          homes = 0;
   int          stops = 0;
   always #10 ref_clk = ~ref_clk;
   // timeout cut to TMO so the run can reach it, yet still above the reply latency
   mdh_top #(.TIMEOUT_CYC(TMO), .CFG_CYC(200)) dut (.ref_clk, .rst_n,
      .server_addr(8'h01), .baud_select_switch, .rx_byte, .rx_error,
      .uif_active, .nvm_busy, .motor_busy, .stop_decel_mode,
      .tx_byte, .tx_ready, .drive_input_command, .home_start, .motor_stop,
      .stop_immediate, .cfg_busy, .alarm_out, .warning_out, .alarm_led, .status,
      .last_error_code);
   mdh_client client (.ref_clk, .slow, .tx_byte, .rx_byte, .tx_ready);
   always @(posedge ref_clk) begin
      if (home_start === 1'b1) homes++;
      if (stop_immediate === 1'b1) stops++;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // one write query, bounded wait for n reply bytes, then for config end
   task automatic wr(input logic [15:0] a, input logic [15:0] v, input int n,
                     input logic [63:0] exp);
      client.send({8'h01, 8'h06, a, v}, 1'b0);
      for (int k = 0; k < 25000 && client.rsp_n < n; k++) tick(1);
      check(client.rsp_n, n);
      if (n == 8)
         check({client.rsp[0], client.rsp[1], client.rsp[2], client.rsp[3],
                client.rsp[4], client.rsp[5], client.rsp[6], client.rsp[7]}, exp);
      for (int k = 0; k < 1000 && cfg_busy !== 1'b0; k++) tick(1);
   endtask
   task automatic pulse_err();
      rx_error = 1'b1;
      tick(1);
      rx_error = 1'b0;
      tick(3);
   endtask
   initial begin
      tick(6);
      rst_n = 1'b1;
      tick(3);
      check(alarm_out, 1'b0);
      rst_n = 1'b0;
      baud_select_switch = 4'h7;
      tick(6);
      rst_n = 1'b1;
      tick(3);
      check(alarm_out, 1'b1);
      check(alarm_led, 1'b0);
      check(last_error_code, 8'h00);
      check(drive_input_command, 16'h0000);
      check(warning_out, 1'b0);
      wr(16'h007d, 16'h0010, 8, 64'h0106007d0010181e);
      check(drive_input_command, 16'h0010);
      check(homes, 1);
      pulse_err();
      check(warning_out, 1'b1);
      check(last_error_code, 8'h84);
      slow = 1'b1;
      stop_decel_mode = 1'b1;
      wr(16'h007d, 16'h0000, 8, 64'h0106007d000019d2);
      slow = 1'b0;
      check(stops, 1);
      check(warning_out, 1'b0);
      check(drive_input_command, 16'h0000);
      wr(16'h007d, 16'h0110, 5, 64'h0);
      check(last_error_code, 8'h8c);
      check(drive_input_command, 16'h0000);
      // busy write: a user session outranks memory and motor
      uif_active = 1'b1;
      nvm_busy = 1'b1;
      motor_busy = 1'b1;
      wr(16'h007d, 16'h0010, 5, 64'h0);
      uif_active = 1'b0;
      nvm_busy = 1'b0;
      motor_busy = 1'b0;
      check(last_error_code, 8'h89);
      check(homes, 1);
      for (int i = 1; i <= 3; i++) begin
         pulse_err();
         check(alarm_out, i < 3);
      end
      check(motor_stop, 1'b1);
      check(stop_immediate, 1'b1);
      check(last_error_code, 8'h84);
      for (int k = 0; k < TMO + 20 && status.timeout !== 1'b1; k++) tick(1);
      check(status.timeout, 1'b1);
      check(last_error_code, 8'h85);
      close_out();
   end
   // the run needs about 82000 cycles
   initial begin
      repeat (95000) @(posedge ref_clk);
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire
